// File: shared/boot_cfg_defs.svh
// Offsets, field positions and reset values of the boot configuration bank
// Functional notes
// R1 - The bank sits at base 0xFFFE6000 with the pin latch at 0x00, the override at 0x04 and the burst map at 0x08.
// R2 - Reading the pin latch returns in bits 3:0 the boot-strap pin levels captured at power-on reset, and it is read-only.
// R3 - Unused upper bits of every register read as zero, and software writes them with their reset value.
// R4 - Override bit 0 reads back whether remapping is effective and is written as the requested control value.
// R5 - The override is effective and reads 1 only when latched pin bit 3 is 1 and the control bit is 1.
// R6 - With latched pin bit 3 at 0 the control bit is ignored for mapping and the status reads 0.
// R7 - Writing 0 to the control bit cancels remapping so the second chip select goes to external memory and reads 0.
// R8 - The control bit takes at power-on reset the level driven on boot-strap pin 6.
// R9 - Boot software writes 0 to the override register as its last act before handing over to the operating system.
// R10 - Each of burst map bits 3 to 0 set to 1 turns bursts to that chip-select region into single transfers.
// R11 - After reset burst splitting is enabled for all four chip-select regions.
// R12 - While the override is effective the second chip-select region is served by the internal boot ROM.
// R13 - Writes to read-only registers and bits are accepted without error and change nothing.
`ifndef BOOT_CFG_DEFS_SVH
`define BOOT_CFG_DEFS_SVH

`define BOOT_CFG_BASE 32'hFFFE6000
`define BOOT_CFG_OFS_PIN_LATCH 12'h000
`define BOOT_CFG_OFS_OVERRIDE 12'h004
`define BOOT_CFG_OFS_BURST_MAP 12'h008
`define BOOT_CFG_OVR_CTRL_POS 0
`define BOOT_CFG_PIN_MODE_POS 3
`define BOOT_CFG_STRAP_PIN6_POS 2
`define BOOT_CFG_BURST_MAP_RST 4'hF
`define BOOT_CFG_LATCH_RST 4'h0

`endif

// File: shared/boot_cfg_pkg.sv
// Types of the boot configuration bank
package boot_cfg_pkg;
  typedef enum logic [2:0] {
    ST_STRAP = 3'b001,
    ST_IDLE = 3'b010,
    ST_RESP = 3'b100
  } boot_cfg_state_t;
endpackage

// File: design/boot_chip_select_config.sv
// Boot configuration register bank with strap latch and chip-select controls
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "boot_cfg_defs.svh"
module boot_chip_select_config
  import boot_cfg_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Boot-strap pins
  input wire logic [3:0] boot_strap_pins_i,
  // Avalon-MM slave
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic avs_response_o,
  // Memory decode controls
  output logic boot_rom_remap_o,
  output logic [3:0] split_bursts_o
);

  // Strap synchroniser
  logic [3:0] strap_meta_ff;
  logic [3:0] strap_sync_ff;
  // Register state
  boot_cfg_state_t state_ff, nxt_state;
  logic [3:0] pin_latch_ff, nxt_pin_latch;
  logic override_ctrl_ff, nxt_override_ctrl;
  logic [3:0] burst_map_ff, nxt_burst_map;
  logic [31:0] rdata_ff, nxt_rdata;
  logic resp_ff, nxt_resp;
  logic override_active;
  logic req;

  // Synchroniser keeps running through reset so the capture sees live straps
  always_ff @(posedge sys_clk_i)
  begin
    strap_meta_ff <= boot_strap_pins_i;
    strap_sync_ff <= strap_meta_ff;
  end

  // Status combines latched mode bit and control bit
  assign override_active = pin_latch_ff[`BOOT_CFG_PIN_MODE_POS] & override_ctrl_ff; // R5 R6 R7
  assign req = avs_read_i | avs_write_i;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_pin_latch = pin_latch_ff;
    nxt_override_ctrl = override_ctrl_ff;
    nxt_burst_map = burst_map_ff;
    nxt_rdata = rdata_ff;
    nxt_resp = resp_ff;
    case (state_ff)
      ST_STRAP:
      begin
        // Capture straps once after reset release
        nxt_pin_latch = strap_sync_ff; // R2
        nxt_override_ctrl = strap_sync_ff[`BOOT_CFG_STRAP_PIN6_POS]; // R8
        nxt_state = ST_IDLE;
      end
      ST_IDLE:
      begin
        if (req)
        begin
          nxt_state = ST_RESP;
          nxt_rdata = 32'h0000_0000; // R3
          nxt_resp = 1'b0;
          case (avs_address_i)
            `BOOT_CFG_OFS_PIN_LATCH:
            begin
              nxt_rdata[3:0] = pin_latch_ff; // R1 R2 R13
            end
            `BOOT_CFG_OFS_OVERRIDE:
            begin
              nxt_rdata[0] = override_active; // R1 R4
              if (avs_write_i && avs_byteenable_i[0])
              begin
                nxt_override_ctrl = avs_writedata_i[`BOOT_CFG_OVR_CTRL_POS]; // R4 R7
              end
            end
            `BOOT_CFG_OFS_BURST_MAP:
            begin
              nxt_rdata[3:0] = burst_map_ff; // R1
              if (avs_write_i && avs_byteenable_i[0])
              begin
                nxt_burst_map = avs_writedata_i[3:0]; // R10 R13
              end
            end
            default:
            begin
              nxt_resp = 1'b1;
            end
          endcase
        end
      end
      ST_RESP:
      begin
        nxt_state = ST_IDLE;
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_ff <= ST_STRAP;
      pin_latch_ff <= `BOOT_CFG_LATCH_RST;
      override_ctrl_ff <= 1'b0;
      burst_map_ff <= `BOOT_CFG_BURST_MAP_RST; // R11
      rdata_ff <= 32'h0000_0000;
      resp_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      pin_latch_ff <= nxt_pin_latch;
      override_ctrl_ff <= nxt_override_ctrl;
      burst_map_ff <= nxt_burst_map;
      rdata_ff <= nxt_rdata;
      resp_ff <= nxt_resp;
    end
  end

  // Waitrequest drops in the response cycle only
  assign avs_waitrequest_o = (state_ff != ST_RESP);
  assign avs_readdata_o = rdata_ff;
  assign avs_response_o = resp_ff;
  assign boot_rom_remap_o = override_active; // R12
  assign split_bursts_o = burst_map_ff; // R10

endmodule
`default_nettype wire

// File: sim/mem_decode_model.sv
// Decode model routing the second chip-select region
`timescale 1ns/1ps
`default_nettype none
module mem_decode_model (
  // Remap level in, boot ROM select out
  input wire logic remap_i,
  output logic rom_serves_o
);
  assign rom_serves_o = remap_i;
endmodule
`default_nettype wire

// File: sim/boot_cfg_asserts.sv
// Port checker of the boot configuration bank
`timescale 1ns/1ps
`default_nettype none
module boot_cfg_asserts (
  // Watched ports
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic boot_rom_remap_o,
  input wire logic [3:0] split_bursts_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  wire logic rd = avs_read_i && !avs_waitrequest_o;
  wire logic wr = avs_write_i && !avs_waitrequest_o;
  wire logic [11:0] ad = avs_address_i;
  wire logic [31:0] q = avs_readdata_o;
  wire logic rm = boot_rom_remap_o;
  wire logic [3:0] sp = split_bursts_o;
  a_upper_zero: assert property (rd |-> q[31:4] == 28'h0) else $error("upper");
  a_status_read: assert property (rd && ad == 12'h004 |-> q[0] == rm) else $error("status");
  a_latch_mode: assert property (rd && ad == 12'h000 && rm |-> q[3]) else $error("mode");
  a_hole_zero: assert property (rd && ad > 12'h008 |-> q == 32'h0) else $error("hole");
  a_split_read: assert property (rd && ad == 12'h008 |-> q[3:0] == sp) else $error("map");
  a_split_hold: assert property ($changed(sp) |-> wr && ad == 12'h008) else $error("hold");
  a_split_reset: assert property ($fell(reset_i) |-> sp == 4'hF) else $error("reset");
  a_remap_hold: assert property ($changed(rm) |-> wr && ad == 12'h004 || $past(reset_i, 2))
    else $error("remap");
  c_status: cover property (rd && ad == 12'h004 && q[0]);
  c_hole: cover property (rd && ad > 12'h008);
  c_map: cover property (wr && ad == 12'h008);
endmodule
bind boot_chip_select_config boot_cfg_asserts i_chk (.*);
`default_nettype wire

// File: sim/tb.sv
// Bench of the boot configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk_i = 1'h0, reset_i = 1'h1, avs_read_i = 1'h0, avs_write_i = 1'h0;
  logic [3:0] boot_strap_pins_i = 4'h0, avs_byteenable_i = 4'hF, split_bursts_o;
  logic [11:0] avs_address_i = 12'h0;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
  logic avs_waitrequest_o, avs_response_o, boot_rom_remap_o, rom;
  logic [3:0] st [3] = '{4'h8, 4'h4, 4'hC};
  int error_cnt = 0, samples_checked = 0;
  always #2.5 sys_clk_i = ~sys_clk_i;
  boot_chip_select_config i_dut (.*);
  mem_decode_model i_dec (.remap_i(boot_rom_remap_o), .rom_serves_o(rom));
  task automatic report_and_stop;
    $display("%0d checks %0d errors", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    samples_checked++;
    if (g !== e) $display("unexpected %0t got %h", $time, g);
    error_cnt += int'(g !== e);
  endtask
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge sys_clk_i);
    {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} <= {!w, w, a, d};
    do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'h0 && ++n < 40);
    {avs_read_i, avs_write_i} <= 2'h0;
    chk({31'h0, avs_response_o}, {31'h0, a > 12'h8});
    chk({31'h0, n == 40}, 32'h0);
    if (n == 40) report_and_stop;
    if (!w) chk(avs_readdata_o, d);
  endtask
  initial
  begin
    foreach (st[i])
    begin
      {reset_i, boot_strap_pins_i} <= {1'h1, st[i]};
      repeat (6) @(posedge sys_clk_i);
      reset_i <= 1'h0;
      acc(1'h1, 12'h0, 32'hF);
      acc(1'h0, 12'h0, {28'h0, st[i]});
      acc(1'h0, 12'h4, {31'h0, st[i][3] & st[i][2]});
      chk({31'h0, rom}, {31'h0, st[i][3] & st[i][2]});
      acc(1'h1, 12'h4, 32'h1);
      acc(1'h0, 12'h4, {31'h0, st[i][3]});
      $display("strap %h done", st[i]);
    end
    acc(1'h0, 12'h8, 32'hF);
    acc(1'h1, 12'h8, 32'hA);
    acc(1'h0, 12'h8, 32'hA);
    acc(1'h1, 12'h4, 32'h0);
    acc(1'h0, 12'h4, 32'h0);
    chk({31'h0, rom}, 32'h0);
    acc(1'h0, 12'hC, 32'h0);
    $display("map and cancel done");
    report_and_stop;
  end
endmodule
`default_nettype wire
